// File: design/tcm_pkg.sv
// constants, types and control word layout of the tape coupler core
// Notes on behaviour
// - status holds zero, carry and sign flags of the last ALU result
// - status flags reload from the ALU result on every control step
// - control store is six byte-wide 512-word memories forming 48 bits
// - each control step latches the addressed word into the pipeline
// - sequencer yields a 9-bit next microaddress, also readable as status
// - fifth field carries one of sixteen next-address instructions
// - conditional sequencer instructions depend on the selected test input; JZ, JMAP, RFCT, RPCT, LDCT and CONT ignore it
// - next address comes from counter, five-entry stack or branch
// - branch targets are the eight bits of the fifth field
// - fourth field bits 4-6 pick one of eight tests when testing
// - tests: no carry, zero, carry, sign, parity, data request, init, true
// - supply low disables the microaddress output and resets the sequencer, pipeline, flags and accumulator; file bytes and tape output hold
// - input bus picks literal, file byte, status, tape data or tape status
// - input source chosen by field one bits 0-2 and field two bit 2
// - upper and lower file byte sources hold their value between steps
// - tape input register bytes reach the input bus under three strobes
// - 32-bit tape output register loads from the result bytewise
// - datapath works on 8-bit bytes with an 8-bit input bus
// - control step period is 200 ns from the system clock
package tcm_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_PERIOD_NS = 200;
  localparam int STEP_CYC = STEP_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_CS_ADDR  = 8'h08;
  localparam logic [7:0] REG_CS_LO    = 8'h0C;
  localparam logic [7:0] REG_CS_HI    = 8'h10;
  localparam logic [7:0] REG_CTL_STAT = 8'h14;
  localparam logic [7:0] REG_PIPE_LO  = 8'h18;
  localparam logic [7:0] REG_PIPE_HI  = 8'h1C;
  localparam logic [7:0] REG_TAPE_OUT = 8'h20;
  localparam logic [7:0] REG_TAPE_IN  = 8'h24;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SRST_BIT = 1;
  localparam int STAT_FLAG_LSB = 16;
  localparam int STAT_SUPPLY_BIT = 20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // control word
  typedef struct packed {
    logic [7:0] lit;   // field six
    logic [7:0] seq;   // field five: instruction low nibble, branch
    logic [7:0] tst;   // field four: [3:0] adr, [6:4] test, [7] test enable
    logic [7:0] fdst;  // field three: [3:0] file adr, [6:4] destination
    logic [7:0] alu;   // field two: [0] add carry in, [2] ext src, [5:3] fn, [6] ld
    logic [7:0] rsel;  // field one: [2:0] input select, [7:4] reg select
  } tcm_cw_t;

  typedef struct packed {
    logic sign;
    logic carry;
    logic zero;
  } tcm_flags_t;

  typedef enum logic [3:0] {
    SQ_JZ, SQ_CJS, SQ_JMAP, SQ_CJP, SQ_PUSH, SQ_JSRP, SQ_CJV, SQ_JRP,
    SQ_RFCT, SQ_RPCT, SQ_CRTN, SQ_CJPP, SQ_LDCT, SQ_LOOP, SQ_CONT, SQ_TWB
  } tcm_seq_t;

  typedef enum logic [2:0] {
    TS_NCARRY, TS_ZERO, TS_CARRY, TS_SIGN, TS_PARITY, TS_DREQ, TS_INIT,
    TS_TRUE
  } tcm_test_t;

  typedef enum logic [2:0] {
    FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR, FN_PASSD, FN_PASSA, FN_ZERO
  } tcm_fn_t;

  // input bus source codes, used when the ext source bit is set
  localparam logic [2:0] DS_FILE_HI = 3'h0;
  localparam logic [2:0] DS_FILE_LO = 3'h1;
  localparam logic [2:0] DS_CTL_ST  = 3'h2;
  localparam logic [2:0] DS_TAPE_A  = 3'h3;
  localparam logic [2:0] DS_TAPE_B  = 3'h4;
  localparam logic [2:0] DS_TAPE_C  = 3'h5;

  // destination codes of field three
  localparam logic [2:0] DST_OUT_A   = 3'h1;
  localparam logic [2:0] DST_OUT_B   = 3'h2;
  localparam logic [2:0] DST_OUT_C   = 3'h3;
  localparam logic [2:0] DST_OUT_D   = 3'h4;
  localparam logic [2:0] DST_FILE_HI = 3'h5;
  localparam logic [2:0] DST_FILE_LO = 3'h6;

  localparam tcm_cw_t PIPE_NOP = 48'h000E_0000_0000;

endpackage

// File: design/tcm_top.sv
// microsequenced control core of the tape coupler with register access
`timescale 1ns/1ns
module tcm_top import tcm_pkg::*; #(
  parameter int UADDR_W = 9,
  parameter int STACK_DEPTH = 5,
  parameter int TAPE_IN_W = 24
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  output logic [1:0]       O_BRESP,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  input  wire logic [7:0]  I_ARADDR,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  input  wire logic [23:0] I_TAPE_IN,
  input  wire logic        I_PARITY,
  input  wire logic        I_DATA_REQ,
  input  wire logic        I_SYS_INIT,
  input  wire logic        I_SUPPLY_LOW_N,
  output logic [31:0]      O_TAPE_OUT,
  output logic [8:0]       O_NEXT_MICROADDR,
  output logic             O_MICROADDR_EN
);

  generate
    if (UADDR_W != 9 || STACK_DEPTH < 1 || STACK_DEPTH > 7 ||
        TAPE_IN_W != 24) begin : g_bad
      $error("tcm_top: unsupported parameter values");
    end
  endgenerate

  localparam int CS_WORDS = 1 << UADDR_W;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  // ==========================================================
  // pin synchronisers
  logic [27:0] sync1_q, sync2_q;
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      sync1_q <= 28'h0000000;
      sync2_q <= 28'h0000000;
    end else begin
      sync1_q <= {I_SUPPLY_LOW_N, I_SYS_INIT, I_DATA_REQ, I_PARITY,
                  I_TAPE_IN};
      sync2_q <= sync1_q;
    end
  end
  logic [23:0] tape_in_s;
  logic        parity_s, dreq_s, init_s, supply_ok;
  assign tape_in_s = sync2_q[23:0];
  assign parity_s  = sync2_q[24];
  assign dreq_s    = sync2_q[25];
  assign init_s    = sync2_q[26];
  // synchroniser resets low, so the core is held until supply is seen good
  assign supply_ok = sync2_q[27];

  // ==========================================================
  // control step divider
  logic [7:0] div_q;
  logic       step_en, step, run_q, srst_q, ctl_rst;
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) div_q <= 8'h00;
    else if (step_en) div_q <= 8'h00;
    else div_q <= 8'(div_q + 8'h01);
  end
  assign step_en = (div_q == 8'(STEP_CYC - 1));
  assign step    = step_en && run_q;
  assign ctl_rst = srst_q || !supply_ok;

  // ==========================================================
  // control store and pipeline
  logic [7:0]  cs_mem [6][CS_WORDS];
  tcm_cw_t     pipe_q, cs_word;
  logic [8:0]  addr_q, y_d, upc, cs_addr_q;
  logic [31:0] cs_lo_q;
  logic [47:0] cs_wr_word;
  logic        cs_commit;
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      cs_word[8*k +: 8] = cs_mem[k][y_d];
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (cs_commit) begin
      for (int k = 0; k < 6; k++) begin
        cs_mem[k][cs_addr_q] <= cs_wr_word[8*k +: 8];
      end
    end
  end
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      pipe_q <= PIPE_NOP;
      addr_q <= 9'h000;
    end else if (ctl_rst) begin
      pipe_q <= PIPE_NOP;
      addr_q <= 9'h000;
    end else if (step) begin
      pipe_q <= cs_word;
      addr_q <= y_d;
    end
  end
  assign upc = 9'(addr_q + 9'h001);
  assign O_NEXT_MICROADDR = addr_q;
  assign O_MICROADDR_EN   = supply_ok;

  // ==========================================================
  // test select and sequencer
  tcm_flags_t flg_q;
  logic       test;
  logic [8:0] branch, cnt_q, stk [STACK_DEPTH], tos;
  logic [2:0] sp_q;
  logic       push, pop, clr, cnt_ld, cnt_dec, cnt_nz;
  tcm_seq_t   op;
  always_comb begin
    test = 1'b1;
    if (pipe_q.tst[7]) begin
      case (tcm_test_t'(pipe_q.tst[6:4]))
        TS_NCARRY: test = !flg_q.carry;
        TS_ZERO:   test = flg_q.zero;
        TS_CARRY:  test = flg_q.carry;
        TS_SIGN:   test = flg_q.sign;
        TS_PARITY: test = parity_s;
        TS_DREQ:   test = dreq_s;
        TS_INIT:   test = init_s;
        default:   test = 1'b1;
      endcase
    end
  end
  assign branch = {1'b0, pipe_q.seq};
  assign op     = tcm_seq_t'(pipe_q.seq[3:0]);
  assign tos    = (sp_q == 3'h0) ? 9'h000 : stk[sp_q - 3'h1];
  assign cnt_nz = (cnt_q != 9'h000);
  always_comb begin
    y_d = upc;
    push = 1'b0;
    pop = 1'b0;
    clr = 1'b0;
    cnt_ld = 1'b0;
    cnt_dec = 1'b0;
    case (op)
      SQ_JZ: begin
        y_d = 9'h000;
        clr = 1'b1;
      end
      SQ_CJS: begin
        push = test;
        if (test) y_d = branch;
      end
      SQ_JMAP: y_d = branch;
      SQ_CJP: if (test) y_d = branch;
      SQ_PUSH: begin
        push = 1'b1;
        cnt_ld = test;
      end
      SQ_JSRP: begin
        push = 1'b1;
        y_d = test ? branch : cnt_q;
      end
      SQ_CJV: if (test) y_d = branch;
      SQ_JRP: y_d = test ? branch : cnt_q;
      SQ_RFCT: begin
        if (cnt_nz) begin
          y_d = tos;
          cnt_dec = 1'b1;
        end else pop = 1'b1;
      end
      SQ_RPCT: begin
        if (cnt_nz) begin
          y_d = branch;
          cnt_dec = 1'b1;
        end
      end
      SQ_CRTN: begin
        pop = test;
        if (test) y_d = tos;
      end
      SQ_CJPP: begin
        pop = test;
        if (test) y_d = branch;
      end
      SQ_LDCT: cnt_ld = 1'b1;
      SQ_LOOP: begin
        pop = test;
        if (!test) y_d = tos;
      end
      SQ_CONT: y_d = upc;
      SQ_TWB: begin
        pop = test || !cnt_nz;
        cnt_dec = !test && cnt_nz;
        if (!test) y_d = cnt_nz ? tos : branch;
      end
      default: y_d = upc;
    endcase
  end
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      sp_q  <= 3'h0;
      cnt_q <= 9'h000;
    end else if (ctl_rst) begin
      sp_q  <= 3'h0;
      cnt_q <= 9'h000;
    end else if (step) begin
      if (cnt_ld) cnt_q <= branch;
      else if (cnt_dec) cnt_q <= 9'(cnt_q - 9'h001);
      if (clr) sp_q <= 3'h0;
      // a push onto a full stack overwrites the top entry
      else if (push && sp_q != 3'(STACK_DEPTH)) sp_q <= 3'(sp_q + 3'h1);
      else if (pop && sp_q != 3'h0) sp_q <= 3'(sp_q - 3'h1);
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (step && push && !ctl_rst) begin
      if (sp_q == 3'(STACK_DEPTH)) stk[sp_q - 3'h1] <= upc;
      else stk[sp_q] <= upc;
    end
  end

  // ==========================================================
  // input bus, ALU and destinations
  logic [7:0]  dbus, acc_q, file_hi_q, file_lo_q, ctl_stat_q, alu_y;
  logic [8:0]  sum;
  logic [23:0] tape_in_q;
  logic [31:0] tape_out_q;
  logic        strobe_a, strobe_b, strobe_c;
  logic [2:0]  dst;

  function automatic logic src_is(tcm_cw_t w, logic [2:0] code);
    return w.alu[2] && (w.rsel[2:0] == code);
  endfunction

  assign strobe_a = src_is(pipe_q, DS_TAPE_A);
  assign strobe_b = src_is(pipe_q, DS_TAPE_B);
  assign strobe_c = src_is(pipe_q, DS_TAPE_C);
  always_comb begin
    dbus = 8'h00;
    if (!pipe_q.alu[2]) dbus = pipe_q.lit;
    else if (src_is(pipe_q, DS_FILE_HI)) dbus = file_hi_q;
    else if (src_is(pipe_q, DS_FILE_LO)) dbus = file_lo_q;
    else if (src_is(pipe_q, DS_CTL_ST)) dbus = ctl_stat_q;
    else if (strobe_a) dbus = tape_in_q[7:0];
    else if (strobe_b) dbus = tape_in_q[15:8];
    else if (strobe_c) dbus = tape_in_q[23:16];
  end
  always_comb begin
    sum = {1'b0, acc_q} + {1'b0, dbus} + {8'h00, pipe_q.alu[0]};
    case (tcm_fn_t'(pipe_q.alu[5:3]))
      FN_SUB:   sum = {1'b0, acc_q} + {1'b0, ~dbus} + 9'h001;
      FN_AND:   sum = {1'b0, acc_q & dbus};
      FN_OR:    sum = {1'b0, acc_q | dbus};
      FN_XOR:   sum = {1'b0, acc_q ^ dbus};
      FN_PASSD: sum = {1'b0, dbus};
      FN_PASSA: sum = {1'b0, acc_q};
      FN_ZERO:  sum = 9'h000;
      default:  ;
    endcase
  end
  assign alu_y = sum[7:0];
  assign dst   = pipe_q.fdst[6:4];
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      flg_q <= '0;
      acc_q <= 8'h00;
    end else if (ctl_rst) begin
      flg_q <= '0;
      acc_q <= 8'h00;
    end else if (step) begin
      flg_q.zero  <= (alu_y == 8'h00);
      flg_q.carry <= sum[8];
      flg_q.sign  <= alu_y[7];
      if (pipe_q.alu[6]) acc_q <= alu_y;
    end
  end
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      file_hi_q <= 8'h00;
      file_lo_q <= 8'h00;
    end else if (step && !ctl_rst) begin
      if (dst == DST_FILE_HI) file_hi_q <= alu_y;
      if (dst == DST_FILE_LO) file_lo_q <= alu_y;
    end
  end
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) tape_in_q <= 24'h000000;
    else if (step) tape_in_q <= tape_in_s;
  end
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) tape_out_q <= 32'h00000000;
    else if (step && !ctl_rst) begin
      if (dst == DST_OUT_A) tape_out_q[7:0] <= alu_y;
      if (dst == DST_OUT_B) tape_out_q[15:8] <= alu_y;
      if (dst == DST_OUT_C) tape_out_q[23:16] <= alu_y;
      if (dst == DST_OUT_D) tape_out_q[31:24] <= alu_y;
    end
  end
  assign O_TAPE_OUT = tape_out_q;

  // ==========================================================
  // register bus slave
  logic [7:0] awaddr_q;
  logic       aw_q, w_q, wr_go;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[8*b +: 8] = n[8*b +: 8];
    end
    return o;
  endfunction

  assign O_AWREADY = !aw_q && !O_BVALID;
  assign O_WREADY  = !w_q && !O_BVALID;
  assign O_ARREADY = !O_RVALID;
  assign wr_go     = aw_q && w_q && !O_BVALID;
  assign cs_commit = wr_go && awaddr_q == REG_CS_HI && wstrb_q != 4'h0;
  // commit takes the held data word: the master may move on once taken
  assign cs_wr_word = {wdata_q[15:0], cs_lo_q};
  logic [31:0] cs_addr_m;
  assign cs_addr_m = merge({23'h000000, cs_addr_q}, wdata_q, wstrb_q);
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_q <= 1'b1;
        awaddr_q <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= (awaddr_q == REG_CTRL || awaddr_q == REG_CS_ADDR ||
                    awaddr_q == REG_CS_LO || awaddr_q == REG_CS_HI ||
                    awaddr_q == REG_CTL_STAT) ? RESP_OKAY : RESP_SLVERR;
      end else if (O_BVALID && I_BREADY) O_BVALID <= 1'b0;
    end
  end
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      run_q <= 1'b0;
      srst_q <= 1'b0;
      cs_addr_q <= 9'h000;
      cs_lo_q <= 32'h00000000;
      ctl_stat_q <= 8'h00;
    end else if (wr_go) begin
      if (awaddr_q == REG_CTRL && wstrb_q[0]) begin
        run_q <= wdata_q[CTRL_RUN_BIT];
        srst_q <= wdata_q[CTRL_SRST_BIT];
      end else if (awaddr_q == REG_CS_ADDR) begin
        cs_addr_q <= cs_addr_m[8:0];
      end else if (awaddr_q == REG_CS_LO) begin
        cs_lo_q <= merge(cs_lo_q, wdata_q, wstrb_q);
      end else if (cs_commit) begin
        cs_addr_q <= 9'(cs_addr_q + 9'h001);
      end else if (awaddr_q == REG_CTL_STAT && wstrb_q[0]) begin
        ctl_stat_q <= wdata_q[7:0];
      end
    end
  end
  logic [31:0] rd_d;
  logic [1:0]  rresp_d;
  always_comb begin
    rresp_d = RESP_OKAY;
    rd_d = 32'h00000000;
    if (I_ARADDR == REG_CTRL) rd_d = {30'h0, srst_q, run_q};
    else if (I_ARADDR == REG_STATUS)
      rd_d = {11'h000, supply_ok, 1'b0, flg_q, 7'h00, addr_q};
    else if (I_ARADDR == REG_CS_ADDR) rd_d = {23'h000000, cs_addr_q};
    else if (I_ARADDR == REG_CS_LO) rd_d = cs_lo_q;
    else if (I_ARADDR == REG_CTL_STAT) rd_d = {24'h000000, ctl_stat_q};
    else if (I_ARADDR == REG_PIPE_LO) rd_d = pipe_q[31:0];
    else if (I_ARADDR == REG_PIPE_HI) rd_d = {16'h0000, pipe_q[47:32]};
    else if (I_ARADDR == REG_TAPE_OUT) rd_d = tape_out_q;
    else if (I_ARADDR == REG_TAPE_IN) rd_d = {8'h00, tape_in_q};
    else if (I_ARADDR != REG_CS_HI) rresp_d = RESP_SLVERR;
  end
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h00000000;
      O_RRESP <= RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      O_RVALID <= 1'b1;
      O_RDATA <= rd_d;
      O_RRESP <= rresp_d;
    end else if (O_RVALID && I_RREADY) O_RVALID <= 1'b0;
  end

  // ==========================================================
  // checks
  sequence s_step_live;
    step && !ctl_rst;
  endsequence
  sequence s_quiet_gap;
    !step_en [*8];
  endsequence

  a_zero_flag: assert property (s_step_live |=>
    flg_q.zero == ($past(alu_y) == 8'h00))
    else $error("zero flag does not follow result");
  a_sign_carry: assert property (s_step_live |=>
    flg_q.sign == $past(alu_y[7]) && flg_q.carry == $past(sum[8]))
    else $error("sign or carry flag wrong");
  a_pipe_load: assert property (s_step_live |=>
    pipe_q == $past(cs_word) && addr_q == $past(y_d))
    else $error("pipeline did not latch store word");
  a_reset_restart: assert property (ctl_rst |=>
    addr_q == 9'h000 && pipe_q == PIPE_NOP)
    else $error("reset did not restart sequencer");
  a_supply_low: assert property (!supply_ok |->
    !O_MICROADDR_EN ##1 addr_q == 9'h000)
    else $error("supply low did not disable address");
  a_branch_taken: assert property (s_step_live and
    (op == SQ_CJP) and test |=> addr_q == {1'b0, $past(pipe_q.seq)})
    else $error("conditional branch not taken");
  a_continue: assert property (s_step_live and (op == SQ_CONT) |=>
    addr_q == 9'($past(addr_q) + 9'h001))
    else $error("continue did not advance");
  a_test_gate: assert property (!pipe_q.tst[7] |-> test)
    else $error("test not forced true");
  a_out_byte: assert property (s_step_live and (dst == DST_OUT_B) |=>
    tape_out_q[15:8] == $past(alu_y) && $stable(tape_out_q[7:0]))
    else $error("output byte b load wrong");
  a_hold_file: assert property (!step |=> $stable(file_hi_q))
    else $error("file holding byte changed");
  a_step_rate: assert property (step_en |=> s_quiet_gap)
    else $error("control step too frequent");

endmodule

// File: tb/tcm_tape_model.sv
// behavioural tape formatter facing the coupler's peripheral pins
`timescale 1ns/1ns
module tcm_tape_model #(
  parameter logic [7:0] DATA_BYTE = 8'hC3,
  parameter logic [7:0] STAT_BYTE = 8'h81,
  parameter logic [7:0] AUX_BYTE  = 8'h3C
) (
  input  wire logic [31:0] i_tape_out,
  output logic [23:0]      o_tape_in,
  output logic             o_parity,
  output logic             o_data_req
);
  // ==========================================================
  // formatter outputs
  // static bytes: the core samples them on every step, so a steady
  // pattern makes each gated byte lane distinguishable
  assign o_tape_in  = {AUX_BYTE, STAT_BYTE, DATA_BYTE};
  assign o_parity   = ^DATA_BYTE;
  assign o_data_req = 1'b0;
endmodule

// File: tb/tape_coupler_microsequencer_test.sv
// register-level bench of the tape coupler control core
`timescale 1ns/1ns
module tape_coupler_microsequencer_test import tcm_pkg::*;;
  localparam logic [23:0] TIN = 24'h3C81C3;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        par, dreq, init, sup_n, awready, wready, bvalid;
  logic        arready, rvalid, uen;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, tape_out;
  logic [1:0]  bresp, rresp;
  logic [8:0]  uaddr;
  logic [23:0] tape_in;
  int          n_fail, check_count;
  bit          seen [512];

  tcm_top i_tcm_top (.I_MCLK(clk), .I_RST(rst), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_AWADDR(awaddr), .I_WVALID(wvalid),
    .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(4'hF), .O_BVALID(bvalid),
    .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp),
    .I_TAPE_IN(tape_in), .I_PARITY(par), .I_DATA_REQ(dreq),
    .I_SYS_INIT(init), .I_SUPPLY_LOW_N(sup_n), .O_TAPE_OUT(tape_out),
    .O_NEXT_MICROADDR(uaddr), .O_MICROADDR_EN(uen));

  tcm_tape_model i_tcm_tape_model (.i_tape_out(tape_out),
    .o_tape_in(tape_in), .o_parity(par), .o_data_req(dreq));

  // ==========================================================
  // helpers
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // waits for the answer however long it takes; the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er}, "read response");
    chk(rdata & m, e, "read data");
  endtask

  // word layout {literal, sequence, test, file/dest, alu, selects}
  task automatic ld(input logic [8:0] a, input logic [47:0] w);
    wr(REG_CS_ADDR, {23'h0, a}, RESP_OKAY);
    wr(REG_CS_LO, w[31:0], RESP_OKAY);
    wr(REG_CS_HI, {16'h0, w[47:32]}, RESP_OKAY);
  endtask

  task automatic watch(input int c);
    foreach (seen[i]) seen[i] = 1'b0;
    repeat (c) begin
      @(posedge clk);
      if (!$isunknown(uaddr)) seen[uaddr] = 1'b1;
    end
  endtask

  // ==========================================================
  // clock, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (10000) @(posedge clk);
    n_fail++;
    end_sim;
  end

  // ==========================================================
  // tests
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, init} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    sup_n = 1'b1;
    rst = 1'b1;
    n_fail = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, uen}, 32'h1, "address enable");
    chk({23'h0, uaddr}, 32'h0, "start address");
    chk(tape_out, 32'h0, "tape out reset");
    rd(REG_STATUS, 32'h001001FF, 32'h00100000, RESP_OKAY);
    rd(REG_PIPE_HI, 32'h0000FFFF, 32'h0000000E, RESP_OKAY);
    rd(REG_PIPE_LO, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    $display("test reset done");
    wr(8'h40, 32'h0, RESP_SLVERR);
    rd(8'h40, 32'h0, 32'h0, RESP_SLVERR);
    wr(REG_STATUS, 32'h0, RESP_SLVERR);
    $display("test refusals done");
    // literal to out byte A; tape byte A to out byte B; jump 0x13;
    // 0x13 jumps to 0x33 only while init is set
    ld(9'h000, 48'h5A0E00106800);
    ld(9'h001, 48'h000E00206C03);
    ld(9'h002, 48'h0013F0000000);
    ld(9'h013, 48'h0033E0000000);
    ld(9'h014, 48'h0);
    ld(9'h033, 48'h0);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    watch(400);
    chk({31'h0, seen[9'h013]}, 32'h1, "branch taken");
    chk({31'h0, seen[9'h014]}, 32'h1, "fall through");
    chk({31'h0, seen[9'h033]}, 32'h0, "false test");
    chk({16'h0, tape_out[15:0]}, {16'h0, TIN[7:0], 8'h5A}, "out");
    rd(REG_TAPE_OUT, 32'h0000FFFF, {16'h0, TIN[7:0], 8'h5A},
       RESP_OKAY);
    rd(REG_TAPE_IN, 32'h00FFFFFF, {8'h0, TIN}, RESP_OKAY);
    $display("test sequencing done");
    init <= 1'b1;
    watch(400);
    chk({31'h0, seen[9'h033]}, 32'h1, "init test");
    init <= 1'b0;
    $display("test condition done");
    sup_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk({31'h0, uen}, 32'h0, "supply low enable");
    chk({23'h0, uaddr}, 32'h0, "supply low address");
    sup_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk({31'h0, uen}, 32'h1, "supply back");
    $display("test supply done");
    end_sim;
  end
endmodule
